// ==== trdw_cfg.svh ====
// Constants for the transfer ring descriptor walker.
`ifndef TRDW_CFG_SVH
`define TRDW_CFG_SVH
`define TRDW_ADDR_W        64
`define TRDW_ENTRY_BYTES   16
`define TRDW_SEG_BYTES     4096
`define TRDW_SEG_ENTRIES   (`TRDW_SEG_BYTES / `TRDW_ENTRY_BYTES)
`define TRDW_LEN_W         17
`define TRDW_LEN_MAX       17'h1_0000
`define TRDW_TYPE_LSB      10
`define TRDW_TYPE_W        6
`define TRDW_CYCLE_BIT     0
`define TRDW_CHAIN_BIT     4
`define TRDW_IOC_BIT       5
`define TRDW_IDT_BIT       6
`define TRDW_NS_BIT        3
`define TRDW_ISP_BIT       2
`define TRDW_SIA_BIT       31
`define TRDW_FRAME_LSB     20
`define TRDW_FRAME_W       11
`define TRDW_TYPE_NORMAL   6'h01
`define TRDW_TYPE_LINK     6'h06
`define TRDW_TYPE_EVTAG    6'h07
`define TRDW_TOGGLE_BIT    1
`define TRDW_EVT_OK        8'h01
`define TRDW_EVT_SHORT     8'h0D
`define TRDW_REG_CTRL      4'h0
`define TRDW_REG_BASE_LO   4'h1
`define TRDW_REG_BASE_HI   4'h2
`define TRDW_REG_STATUS    4'h3
`define TRDW_REG_DEQ_LO    4'h4
`define TRDW_REG_DEQ_HI    4'h5
`define TRDW_REG_TDLEN     4'h6
`define TRDW_REG_TDCOUNT   4'h7
`define TRDW_CTRL_RUN      0
`define TRDW_CTRL_LOAD     1
`define TRDW_CTRL_DOORBELL 2
`endif

// ==== trdw_fetch.sv ====
// Fetch unit: reads one sixteen-byte ring entry from host memory.
`timescale 1ns/1ns
`include "trdw_cfg.svh"
module trdw_fetch (
	input  wire logic   mclk,
	input  wire logic   rstn,
	trdw_mem_if.fetch   mem,
	output logic        rd_req,
	output logic [63:0] rd_addr,
	input  wire logic   rd_valid,
	input  wire logic [127:0] rd_data
);
	logic busy;

	// One outstanding read; the entry is held until the walker asks again.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			busy     <= 1'b0;
			rd_req   <= 1'b0;
			rd_addr  <= 64'h0000_0000_0000_0000;
			mem.ack  <= 1'b0;
			mem.data <= 128'h0;
		end else begin
			rd_req  <= mem.req && !busy && !mem.ack;
			mem.ack <= 1'b0;
			if (mem.req && !busy && !mem.ack) begin
				busy    <= 1'b1;
				rd_addr <= mem.addr;
			end
			if (busy && rd_valid) begin
				busy     <= 1'b0;
				mem.ack  <= 1'b1;
				mem.data <= rd_data;
			end
		end
	end
endmodule // trdw_fetch

// ==== trdw_host_mem.sv ====
// Host memory model: one ring segment that answers entry fetches.
`timescale 1ns/1ns
module trdw_host_mem (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic         rd_req,
	input  wire logic [63:0]  rd_addr,
	output logic              rd_valid,
	output logic [127:0]      rd_data
);
	// Entries are filled whole by the bench before the doorbell.
	logic [127:0] ring [0:255]; // 256 entries of 16 bytes fill 4K.
	logic [7:0]   idx;
	logic [1:0]   wait_n;
	logic         busy;
	logic         slow;
	initial for (int i = 0; i < 256; i++) ring[i] = 128'h0;
	// Answers alternate between prompt and slow; idle data lines toggle.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_valid <= 1'b0;
			rd_data <= 128'h0;
			busy <= 1'b0;
			slow <= 1'b0;
			wait_n <= 2'h0;
			idx <= 8'h00;
		end else begin
			rd_valid <= 1'b0;
			rd_data <= ~rd_data;
			if (rd_req) begin
				busy <= 1'b1;
				idx <= rd_addr[11:4];
				wait_n <= slow ? 2'h3 : 2'h0;
				slow <= ~slow;
			end else if (busy && wait_n != 2'h0) begin
				wait_n <= wait_n - 2'h1;
			end else if (busy) begin
				busy <= 1'b0;
				rd_valid <= 1'b1;
				rd_data <= ring[idx];
			end
		end
	end
endmodule // trdw_host_mem

// ==== trdw_mem_if.sv ====
// Memory request and answer signals between walker and fetch unit.
`timescale 1ns/1ns
interface trdw_mem_if;
	logic        req;
	logic [63:0] addr;
	logic        ack;
	logic [127:0] data;
	modport walker (output req, output addr, input ack, input data);
	modport fetch  (input req, input addr, output ack, output data);
endinterface

// ==== trdw_mover.sv ====
// Byte mover: counts one entry's buffer bytes onto the endpoint stream.
`timescale 1ns/1ns
`include "trdw_cfg.svh"
module trdw_mover #(
	parameter int LEN_W = `TRDW_LEN_W
) (
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic             start,
	input  wire logic [63:0]      buf_addr,
	input  wire logic [LEN_W-1:0] length,
	input  wire logic             ep_ready,
	output logic                  ep_valid,
	output logic [63:0]           ep_addr,
	output logic                  done
);
	logic [LEN_W-1:0] left;

	// Any byte alignment is taken; the address steps one byte per beat.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			left     <= '0;
			ep_valid <= 1'b0;
			ep_addr  <= 64'h0000_0000_0000_0000;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				left     <= length;
				ep_addr  <= buf_addr;
				ep_valid <= (length != '0);
				done     <= (length == '0);
			end else if (ep_valid && ep_ready) begin
				left    <= left - 1'b1;
				ep_addr <= ep_addr + 64'h0000_0000_0000_0001;
				if (left == {{(LEN_W-1){1'b0}}, 1'b1}) begin
					ep_valid <= 1'b0;
					done     <= 1'b1;
				end
			end
		end
	end
endmodule // trdw_mover

// ==== trdw_pkg.sv ====
// Types shared by the transfer ring descriptor walker modules.
package trdw_pkg;
	typedef enum logic [2:0] {
		TRDW_IDLE  = 3'b000,
		TRDW_FETCH = 3'b001,
		TRDW_WAIT  = 3'b010,
		TRDW_DECODE = 3'b011,
		TRDW_MOVE  = 3'b100,
		TRDW_EVENT = 3'b101
	} trdw_state_t;
	typedef struct packed {
		logic [31:0] control;
		logic [31:0] status;
		logic [63:0] pointer;
	} trdw_entry_t;
endpackage

// ==== trdw_walker.sv ====
// Transfer ring walker: follows consumer position, links and chains.
`timescale 1ns/1ns
`include "trdw_cfg.svh"
// Summary of operation
// - All ring types share one circular queue walk; this is a transfer ring.
// - Ring equal producer and consumer means empty; nothing then executes.
// - Positions are internal logic values, never exposed as ring registers; the consumer position here reads back, not writable, at offsets 4 and 5.
// - A link entry redirects the walk to the segment address it names.
// - Entry is 64-bit pointer or data, 32-bit status, 32-bit control.
// - Entries are sixteen bytes, so 256 fit a 4K segment.
// - Buffer addresses are accepted at any byte alignment.
// - Byte count in status word, any size from 0 to 64K.
// - Chained buffers are joined into one stream, consumer to producer.
// - Completed entries may post length and status as transfer event.
// - Event tag entries return their 64-bit tag when descriptor completes.
// - Segments may be added or removed while the ring is walked.
module trdw_walker (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic [3:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic [31:0]       reg_rdata,
	output logic              rd_req,
	output logic [63:0]       rd_addr,
	input  wire logic         rd_valid,
	input  wire logic [127:0] rd_data,
	output logic              ep_valid,
	output logic [63:0]       ep_addr,
	input  wire logic         ep_ready,
	output logic              ep_last,
	output logic              evt_valid,
	output logic [63:0]       evt_tag,
	output logic [31:0]       evt_status,
	output logic              evt_is_tag,
	input  wire logic         evt_ready
);
	// Walker to fetch unit handshake.
	trdw_mem_if mem ();
	trdw_pkg::trdw_state_t state;
	trdw_pkg::trdw_state_t next_state;
	trdw_pkg::trdw_entry_t entry;
	logic        run;
	logic        cycle_state;
	logic [31:0] base_lo;
	logic [31:0] base_hi;
	logic [63:0] deq;
	logic [31:0] td_len;
	logic [31:0] td_count;
	logic        doorbell;
	logic        empty_seen;
	logic        mv_start;
	logic        mv_done;
	logic [`TRDW_LEN_W-1:0] beats_left;
	logic        req;
	logic [31:0] rdata_next;

	// Field extraction from the fetched entry, used in several places.
	function automatic logic [`TRDW_TYPE_W-1:0] entry_type(
		input logic [31:0] ctl);
		entry_type = ctl[`TRDW_TYPE_LSB +: `TRDW_TYPE_W];
	endfunction

	// A set bit 16 stands for the full 64K count, since sixteen bits alone
	// cannot hold it.
	function automatic logic [`TRDW_LEN_W-1:0] entry_len(
		input logic [31:0] sts);
		logic [`TRDW_LEN_W-1:0] l;
		l = {1'b0, sts[15:0]};
		if (sts[16])
			l = `TRDW_LEN_MAX;
		entry_len = l;
	endfunction

	// Decoded fields of the latched entry and the register strobes.
	// Fields are read from the held copy, never from the memory bus.
	wire [31:0] ctl       = entry.control;
	wire        is_link   = entry_type(ctl) == `TRDW_TYPE_LINK;
	wire        is_tag    = entry_type(ctl) == `TRDW_TYPE_EVTAG;
	wire        chain     = ctl[`TRDW_CHAIN_BIT];
	wire        irq_on_completion_flag       = ctl[`TRDW_IOC_BIT];
	wire        immediate_payload_flag       = ctl[`TRDW_IDT_BIT];
	wire        owned     = ctl[`TRDW_CYCLE_BIT] == cycle_state;
	wire [63:0] buf_ptr   = immediate_payload_flag ? deq : entry.pointer;
	wire [`TRDW_LEN_W-1:0] len = entry_len(entry.status);
	wire        wr_ctrl   = reg_wr && reg_addr == `TRDW_REG_CTRL;
	wire        load      = wr_ctrl && reg_wdata[`TRDW_CTRL_LOAD];
	wire        ring_bell = wr_ctrl && reg_wdata[`TRDW_CTRL_DOORBELL];
	wire [63:0] seg_base  = {base_hi, base_lo};
	wire [63:0] deq_step  = deq + 64'(`TRDW_ENTRY_BYTES);
	wire        tag_go    = state == trdw_pkg::TRDW_DECODE && owned && run &&
		is_tag;
	// An unchained data entry or tag entry closes the descriptor.
	wire        td_close  = ((state == trdw_pkg::TRDW_MOVE && mv_done) ||
		tag_go) && !chain;

	assign mem.addr = deq;
	assign mem.req  = req;

	// Entry fetches go through a one-deep fetch unit; the walker never has
	// more than one read open, so no reorder logic is needed on answers.
	trdw_fetch u_fetch (
		.mclk     (mclk),
		.rstn     (rstn),
		.mem      (mem.fetch),
		.rd_req   (rd_req),
		.rd_addr  (rd_addr),
		.rd_valid (rd_valid),
		.rd_data  (rd_data)
	);

	// The mover owns the beat handshake and drives the valid and address pins straight
	// from its registers, so valid and address always belong together.
	trdw_mover #(.LEN_W(`TRDW_LEN_W)) u_mover (
		.mclk     (mclk),
		.rstn     (rstn),
		.start    (mv_start),
		.buf_addr (buf_ptr),
		.length   (len),
		.ep_ready (ep_ready),
		.ep_valid (ep_valid),
		.ep_addr  (ep_addr),
		.done     (mv_done)
	);

	// State transitions; a non-owned entry is where the ring is empty.
	// A link is followed without touching the stream, and a completion
	// event holds the walk until the event sink has taken it, so events
	// always leave in ring order.
	always_comb begin
		next_state = state;
		req        = 1'b0;
		case (state)
			trdw_pkg::TRDW_IDLE: begin
				if (run && doorbell)
					next_state = trdw_pkg::TRDW_FETCH;
			end
			trdw_pkg::TRDW_FETCH: begin
				req        = 1'b1;
				next_state = trdw_pkg::TRDW_WAIT;
			end
			trdw_pkg::TRDW_WAIT: begin
				req = 1'b1;
				if (mem.ack)
					next_state = trdw_pkg::TRDW_DECODE;
			end
			trdw_pkg::TRDW_DECODE: begin
				if (!owned || !run)
					next_state = trdw_pkg::TRDW_IDLE;
				else if (is_link)
					next_state = trdw_pkg::TRDW_FETCH;
				else if (is_tag)
					next_state = trdw_pkg::TRDW_EVENT;
				else
					next_state = trdw_pkg::TRDW_MOVE;
			end
			trdw_pkg::TRDW_MOVE: begin
				if (mv_done)
					next_state = (irq_on_completion_flag || !chain) && irq_on_completion_flag ?
						trdw_pkg::TRDW_EVENT : trdw_pkg::TRDW_FETCH;
			end
			trdw_pkg::TRDW_EVENT: begin
				if (evt_valid && evt_ready)
					next_state = trdw_pkg::TRDW_FETCH;
			end
			default: next_state = trdw_pkg::TRDW_IDLE;
		endcase
	end

	// A buffer move starts only from a decoded, owned data entry; link and
	// tag entries carry no payload.
	assign mv_start = state == trdw_pkg::TRDW_DECODE && owned && run &&
		!is_link && !is_tag;

	// Walker state and the entry latched from memory.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state <= trdw_pkg::TRDW_IDLE;
			entry <= '0;
		end else begin
			state <= next_state;
			if (mem.ack)
				entry <= trdw_pkg::trdw_entry_t'(mem.data);
		end
	end

	// Consumer position: advance per entry, jump on link, reload on load.
	// The producer side is only seen through the cycle bit, so growing or
	// shrinking the ring needs nothing more than honest link entries.
	// A link clears the low four bits of its target so fetches stay on
	// entry boundaries whatever software wrote.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			deq         <= 64'h0000_0000_0000_0000;
			cycle_state <= 1'b1;
		end else if (load) begin
			deq         <= seg_base;
			cycle_state <= 1'b1;
		end else if (state == trdw_pkg::TRDW_DECODE && owned && run) begin
			if (is_link) begin
				deq <= {entry.pointer[63:4], 4'h0};
				if (ctl[`TRDW_TOGGLE_BIT])
					cycle_state <= !cycle_state;
			end else begin
				deq <= deq_step;
			end
		end
	end

	// Descriptor totals: bytes summed across chained entries. The sum
	// restarts when a new descriptor begins or on load, so the last finished
	// total stays readable after the walk idles.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			td_len   <= 32'h0000_0000;
			td_count <= 32'h0000_0000;
		end else if (load) begin
			td_len   <= 32'h0000_0000;
			td_count <= 32'h0000_0000;
		end else if (mv_start) begin
			td_len <= (empty_seen ? 32'h0000_0000 : td_len) + 32'(len);
		end else if (td_close) begin
			td_count <= td_count + 32'h0000_0001;
		end
	end

	// Tracks that the previous descriptor closed, so its total restarts.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			empty_seen <= 1'b0;
		else if (td_close)
			empty_seen <= 1'b1;
		else if (mv_start)
			empty_seen <= 1'b0;
	end

	// The last flag counts the beats down beside the mover, so it drops
	// in the same edge as the final beat of an unchained entry.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			beats_left <= '0;
			ep_last    <= 1'b0;
		end else if (mv_start) begin
			beats_left <= len;
			ep_last    <= !chain && len != '0;
		end else if (ep_valid && ep_ready) begin
			beats_left <= beats_left - 1'b1;
			if (beats_left == {{(`TRDW_LEN_W-1){1'b0}}, 1'b1})
				ep_last <= 1'b0;
		end
	end

	// Completion events: length report or returned tag.
	// Only one event is ever pending: the walker waits in its event state,
	// so a new completion cannot overwrite one the sink has not taken.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			evt_valid  <= 1'b0;
			evt_tag    <= 64'h0000_0000_0000_0000;
			evt_status <= 32'h0000_0000;
			evt_is_tag <= 1'b0;
		end else if (evt_valid && evt_ready) begin
			evt_valid <= 1'b0;
		end else if (state == trdw_pkg::TRDW_DECODE && owned && run &&
			is_tag) begin
			evt_valid  <= 1'b1;
			evt_tag    <= entry.pointer;
			evt_status <= {`TRDW_EVT_OK, td_len[23:0]};
			evt_is_tag <= 1'b1;
		end else if (state == trdw_pkg::TRDW_MOVE && mv_done && irq_on_completion_flag) begin
			evt_valid  <= 1'b1;
			evt_tag    <= deq - 64'(`TRDW_ENTRY_BYTES);
			evt_status <= {`TRDW_EVT_OK, 7'h00, len};
			evt_is_tag <= 1'b0;
		end
	end

	// Control registers; the doorbell stays set until a non-owned entry is decoded.
	// Clearing run does not abort a move in flight; the walk stops at the
	// next decode, which keeps the stream from being cut mid-entry.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			run      <= 1'b0;
			base_lo  <= 32'h0000_0000;
			base_hi  <= 32'h0000_0000;
			doorbell <= 1'b0;
		end else begin
			if (wr_ctrl)
				run <= reg_wdata[`TRDW_CTRL_RUN];
			if (reg_wr && reg_addr == `TRDW_REG_BASE_LO)
				base_lo <= {reg_wdata[31:4], 4'h0};
			if (reg_wr && reg_addr == `TRDW_REG_BASE_HI)
				base_hi <= reg_wdata;
			if (ring_bell)
				doorbell <= 1'b1;
			else if (state == trdw_pkg::TRDW_DECODE && !owned)
				doorbell <= 1'b0;
		end
	end

	// Read decode; unmapped offsets answer zero. The consumer position is
	// visible only as a debug view, not as a writable ring register.
	always_comb begin
		case (reg_addr)
			`TRDW_REG_CTRL:    rdata_next = {31'h0, run};
			`TRDW_REG_BASE_LO: rdata_next = base_lo;
			`TRDW_REG_BASE_HI: rdata_next = base_hi;
			`TRDW_REG_STATUS:  rdata_next = {26'h0, doorbell, cycle_state,
				1'b0, state};
			`TRDW_REG_DEQ_LO:  rdata_next = deq[31:0];
			`TRDW_REG_DEQ_HI:  rdata_next = deq[63:32];
			`TRDW_REG_TDLEN:   rdata_next = td_len;
			`TRDW_REG_TDCOUNT: rdata_next = td_count;
			default:           rdata_next = 32'h0000_0000;
		endcase
	end

	// Read data stands in the cycle after the strobe only.
	// Zero outside that cycle keeps a shared read-data bus free of stale
	// values.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
	end
endmodule // trdw_walker

// ==== trdw_walker_checker.sv ====
// Port-level assertions for the transfer ring walker.
`timescale 1ns/1ns
`include "trdw_cfg.svh"
module trdw_walker_checker (
	input wire logic         mclk,
	input wire logic         rstn,
	input wire logic [3:0]   reg_addr,
	input wire logic [31:0]  reg_wdata,
	input wire logic         reg_wr,
	input wire logic         reg_rd,
	input wire logic [31:0]  reg_rdata,
	input wire logic         rd_req,
	input wire logic [63:0]  rd_addr,
	input wire logic         rd_valid,
	input wire logic         ep_valid,
	input wire logic         ep_ready,
	input wire logic         ep_last,
	input wire logic         evt_valid,
	input wire logic [63:0]  evt_tag,
	input wire logic [31:0]  evt_status,
	input wire logic         evt_is_tag,
	input wire logic         evt_ready
);
	logic pend;
	logic run;
	// Track the open fetch and the run bit, since fetches need both.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pend <= 1'b0;
			run <= 1'b0;
		end else begin
			pend <= rd_req | (pend & ~rd_valid);
			if (reg_wr && reg_addr == `TRDW_REG_CTRL)
				run <= reg_wdata[`TRDW_CTRL_RUN];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_req;
		rd_req ##1 !rd_req;
	endsequence
	sequence s_evt_hold;
		evt_valid && $stable(evt_tag) && $stable(evt_is_tag);
	endsequence
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside the answer cycle");
	a_req_pulse: assert property (rd_req |-> s_req)
		else $error("fetch request longer than one cycle");
	a_one_pending: assert property (pend && !rd_valid |-> !rd_req)
		else $error("second fetch while one is open");
	a_entry_align: assert property (rd_req |-> rd_addr[3:0] == 4'h0)
		else $error("fetch address not on an entry boundary");
	a_fetch_run: assert property (rd_req |-> run)
		else $error("fetch while the walk is stopped");
	a_last_beat: assert property (ep_last |-> ep_valid)
		else $error("last flag without a beat");
	a_beat_hold: assert property (ep_valid && !ep_ready |=> ep_valid)
		else $error("beat dropped while stalled");
	a_evt_hold: assert property (evt_valid && !evt_ready |=> s_evt_hold)
		else $error("event changed while stalled");
	a_evt_code: assert property (
		evt_valid |-> evt_status[31:24] == `TRDW_EVT_OK)
		else $error("wrong event completion code");
endmodule // trdw_walker_checker
bind trdw_walker trdw_walker_checker u_chk (.mclk, .rstn, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rd_req, .rd_addr, .rd_valid,
	.ep_valid, .ep_ready, .ep_last, .evt_valid, .evt_tag, .evt_status,
	.evt_is_tag, .evt_ready);

// ==== trdw_walker_tb.sv ====
// Self-checking bench for the transfer ring walker.
`timescale 1ns/1ns
`include "trdw_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module trdw_walker_tb;
	logic         mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0]   reg_addr = 4'h0;
	logic [31:0]  reg_wdata = 32'h0, reg_rdata;
	logic         rd_req, rd_valid, ep_valid, ep_last, evt_valid, evt_is_tag;
	logic         ep_ready = 0, evt_ready = 0;
	logic [63:0]  rd_addr, ep_addr, evt_tag;
	logic [127:0] rd_data;
	logic [31:0]  evt_status;
	logic [63:0]  tags[$];
	logic [63:0]  addrs[$];
	logic [31:0]  stats[$];
	logic         is_tags[$];
	int           failures = 0, checked = 0, beats = 0, lasts = 0;
	always #20 mclk = ~mclk;
	trdw_walker uut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .rd_req, .rd_addr, .rd_valid, .rd_data, .ep_valid,
		.ep_addr, .ep_ready, .ep_last, .evt_valid, .evt_tag, .evt_status,
		.evt_is_tag, .evt_ready);
	trdw_host_mem host (.mclk, .rstn, .rd_req, .rd_addr, .rd_valid, .rd_data);
	// Both sinks stall every other cycle so holding is exercised.
	always @(posedge mclk) begin
		ep_ready <= ~ep_ready;
		evt_ready <= ep_ready;
		if (ep_valid && ep_ready) begin
			beats++;
			addrs.push_back(ep_addr);
		end
		if (ep_valid && ep_ready && ep_last) lasts++;
		if (evt_valid && evt_ready) begin
			tags.push_back(evt_tag);
			is_tags.push_back(evt_is_tag);
			stats.push_back(evt_status);
		end
	end
	// Flags: bit0 cycle, bit1 toggle, bit4 chain, bit5 completion event.
	function automatic logic [127:0] ent(logic [63:0] p, logic [16:0] n,
		logic [5:0] ty, logic [9:0] fl);
		trdw_pkg::trdw_entry_t e;
		e.pointer = p;
		e.status = {15'h0, n};
		e.control = {16'h0, ty, fl};
		return e;
	endfunction
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task chk_reg(input string n, input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 `CHK(n, e, reg_rdata)
	endtask
	// Polls until the doorbell drops and the walk is idle, then drains.
	task settle;
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge mclk);
			reg_addr <= `TRDW_REG_STATUS;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 if (reg_rdata[5] === 1'b0 && reg_rdata[2:0] === 3'h0) break;
		end
		if (i == 200) begin
			failures++;
			wrap_up();
		end
		repeat (20) @(posedge mclk);
	endtask
	task wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task t_reset;
		chk_reg("status", `TRDW_REG_STATUS, 32'h0000_0010);
		wr(`TRDW_REG_DEQ_LO, 32'hFFFF_FFF0);
		chk_reg("deq read only", `TRDW_REG_DEQ_LO, 32'h0);
		chk_reg("unmapped", 4'h8, 32'h0);
	endtask
	task t_empty;
		wr(`TRDW_REG_BASE_LO, 32'h0000_1000);
		wr(`TRDW_REG_BASE_HI, 32'h0);
		wr(`TRDW_REG_CTRL, 32'h0000_0003);
		chk_reg("cycle after load", `TRDW_REG_STATUS, 32'h0000_0010);
		wr(`TRDW_REG_CTRL, 32'h0000_0005);
		settle();
		`CHK("beats on empty", 0, beats)
		chk_reg("deq empty", `TRDW_REG_DEQ_LO, 32'h0000_1000);
	endtask
	task t_chain;
		host.ring[0] = ent(64'h2001, 17'h3, `TRDW_TYPE_NORMAL, 10'h011);
		host.ring[1] = ent(64'h2F00, 17'h0, `TRDW_TYPE_NORMAL, 10'h011);
		host.ring[2] = ent(64'h3000, 17'h2, `TRDW_TYPE_NORMAL, 10'h021);
		host.ring[3] = ent(64'h1000, 17'h0, `TRDW_TYPE_LINK, 10'h003);
		wr(`TRDW_REG_CTRL, 32'h0000_0005);
		settle();
		`CHK("beats", 5, beats)
		`CHK("last beats", 2, lasts)
		chk_reg("td length", `TRDW_REG_TDLEN, 32'h5);
		chk_reg("td count", `TRDW_REG_TDCOUNT, 32'h1);
		chk_reg("deq after link", `TRDW_REG_DEQ_LO, 32'h0000_1000);
		chk_reg("toggled cycle", `TRDW_REG_STATUS, 32'h0);
		`CHK("events", 1, tags.size())
		if (tags.size() > 0) `CHK("plain event", 1'b0, is_tags[0])
		if (stats.size() > 0)
			`CHK("event status", 32'h0100_0002, stats[0])
		if (addrs.size() > 3) begin
			`CHK("first byte", 64'h2001, addrs[0])
			`CHK("third byte", 64'h2003, addrs[2])
			`CHK("joined byte", 64'h3000, addrs[3])
		end
	endtask
	task t_tag;
		host.ring[0] = ent(64'h0123_4567_89AB_CDEF, 17'h0, `TRDW_TYPE_EVTAG,
			10'h020);
		wr(`TRDW_REG_CTRL, 32'h0000_0005);
		settle();
		`CHK("events", 2, tags.size())
		if (tags.size() > 1) begin
			`CHK("tag", 64'h0123_4567_89AB_CDEF, tags[1])
			`CHK("tag event", 1'b1, is_tags[1])
			`CHK("tag status", 32'h0100_0005, stats[1])
		end
		chk_reg("td count", `TRDW_REG_TDCOUNT, 32'h2);
		chk_reg("deq next", `TRDW_REG_DEQ_LO, 32'h0000_1010);
	endtask
	// Reset is held for eight cycles, then the scenarios run in turn.
	initial begin
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		t_reset();
		t_empty();
		t_chain();
		t_tag();
		wrap_up();
	end
endmodule // trdw_walker_tb
